// file: design/bit_sync2.sv
`timescale 1ns/10ps
module bit_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage is read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// file: design/ripple_prescaler.sv
`timescale 1ns/10ps
module ripple_prescaler (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       tick,
  input  wire logic [1:0] ratio,
  output logic            pulse,
  output logic            level
);
  logic [2:0] cnt_r;
  wire  [2:0] limit = 3'((4'd1 << ratio) - 4'd1);
  wire        wrap  = tick && (cnt_r >= limit);

  // level toggles once per output period, pulse marks the same moment
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
      pulse <= 1'b0;
      level <= 1'b0;
    end else begin
      pulse <= wrap && !clear;
      if (clear) begin
        cnt_r <= 3'h0;
      end else if (wrap) begin
        cnt_r <= 3'h0;
        level <= ~level;
      end else if (tick) begin
        cnt_r <= cnt_r + 3'h1;
      end
    end
  end
endmodule

// file: design/sixteen_bit_timer_counter.sv
// Summary of operation
// - count runs 0000 to ffff, then wraps
// - wrap sets flag; enable gates interrupt
// - source select: external rising edges or fosc/4
// - internal source ignores the bypass bit
// - run bit starts counting; clear holds value
// - divide field picks 1:1, 1:2, 1:4, 1:8
// - oscillator enable forces pins input, reads zero
// - external edges from crystal or count pin
// - pins synchronised before the prescaler; synced mode resamples again after it
// - synced counting holds in sleep; prescaler runs
// - bypass counts asynchronously, runs in sleep
// - async counting is no capture/compare timebase
// - count byte reads are always stable
// - special event trigger mode clears count
// - trigger clear never sets the flag
// - trigger clear only in synced modes
// - count write beats a coincident trigger
// - count byte write clears the prescaler
// - count survives resets; control clears on power-on
`timescale 1ns/10ps
module sixteen_bit_timer_counter (
  input  wire logic                     ref_clk,
  input  wire logic                     resetn,
  input  wire logic                     other_reset,
  input  wire logic [tmr_pkg::ADDR_W-1:0] paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     ext_count_pin,
  input  wire logic                     crystal_in_pin,
  input  wire logic [1:0]               portc_direction,
  input  wire logic [1:0]               portc_pin_in,
  output logic      [1:0]               portc_pin_oe,
  output logic      [1:0]               portc_read,
  input  wire logic                     sleep_mode,
  input  wire logic                     ccu_trigger,
  input  wire logic [3:0]               ccu_mode_field,
  output logic      [15:0]              count_value,
  output logic                          timebase_valid,
  output logic                          overflow_irq
);
  import tmr_pkg::*;

  // ****************************************************
  // reset release
  // ****************************************************
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // ****************************************************
  // state
  // ****************************************************
  counter_control_t ctrl_r;
  logic [15:0]      count_r;
  logic [15:0]      count_nxt;
  logic             flag_r;
  logic             flag_nxt;
  logic             ien_r;
  logic [1:0]       instr_div_r;
  logic [3:0]       pins_s;
  logic             ext_d_r;
  logic             pre_pulse;
  logic             pre_level;
  logic             pre_level_s;
  logic             pre_level_d_r;
  apb_req_t         req;

  assign req = '{paddr: paddr, psel: psel, penable: penable,
                 pwrite: pwrite, pwdata: pwdata};

  // ****************************************************
  // apb decode
  // ****************************************************
  wire setup    = req.psel && !req.penable;
  wire wr_go    = req.psel && req.penable && pready && req.pwrite;
  wire sel_flag = req.paddr == FLAG_ADDR;
  wire sel_low  = req.paddr == LOW_ADDR;
  wire sel_high = req.paddr == HIGH_ADDR;
  wire sel_ctrl = req.paddr == CTRL_ADDR;
  wire sel_ien  = req.paddr == IEN_ADDR;
  wire mapped   = sel_flag | sel_low | sel_high | sel_ctrl | sel_ien;
  wire wr_low   = wr_go && sel_low;
  wire wr_high  = wr_go && sel_high;
  wire wr_ctrl  = wr_go && sel_ctrl;
  wire wr_flag  = wr_go && sel_flag;
  wire wr_ien   = wr_go && sel_ien;
  wire wr_count = wr_low || wr_high;

  // count is one register in the clock domain, so byte reads never tear
  wire [7:0] rd_byte =
      sel_low  ? count_r[7:0] :
      sel_high ? count_r[15:8] :
      sel_ctrl ? (ctrl_r & CTRL_MASK) :
      sel_flag ? {7'h00, flag_r} :
      sel_ien  ? {7'h00, ien_r} : 8'h00;

  // one wait-free access: data and answer are latched in setup
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      if (setup) begin
        prdata  <= {24'h00_0000, rd_byte};
        pslverr <= !mapped;
      end
    end
  end

  // ****************************************************
  // control register
  // ****************************************************
  // only the power-on reset clears it; other_reset leaves it alone
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= req.pwdata[7:0] & CTRL_MASK;
    end
  end

  wire       run    = ctrl_r.run_bit;
  wire       ext    = ctrl_r.source_select;
  wire       bypass = ext && ctrl_r.sync_bypass;
  wire       osc_en = ctrl_r.crystal_osc_enable;
  wire [1:0] ratio  = ctrl_r.input_divide_select;

  // ****************************************************
  // pins
  // ****************************************************
  bit_sync2 #(.W(4)) u_pin_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .d     ({crystal_in_pin, ext_count_pin, portc_pin_in}),
    .q     (pins_s)
  );

  wire ext_src  = osc_en ? pins_s[3] : pins_s[2];
  wire ext_rise = ext_src && !ext_d_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_d_r      <= 1'b0;
      portc_pin_oe <= 2'b00;
      portc_read   <= 2'b00;
    end else begin
      ext_d_r      <= ext_src;
      portc_pin_oe <= osc_en ? 2'b00 : ~portc_direction;
      portc_read   <= osc_en ? 2'b00 : pins_s[1:0];
    end
  end

  // ****************************************************
  // instruction clock: fosc/4 enable
  // ****************************************************
  wire instr_tick = instr_div_r == 2'(INSTR_CYCLES - 1);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_div_r <= 2'b00;
    end else begin
      instr_div_r <= instr_tick ? 2'b00 : instr_div_r + 2'b01;
    end
  end

  // ****************************************************
  // prescaler and second synchronising stage
  // ****************************************************
  // the core clock stops in sleep, so the internal source does too
  wire int_tick = instr_tick && !sleep_mode;
  wire pre_in   = run && (ext ? ext_rise : int_tick);

  ripple_prescaler u_pre (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .clear (wr_count),
    .tick  (pre_in),
    .ratio (ratio),
    .pulse (pre_pulse),
    .level (pre_level)
  );

  // synced mode resamples the prescaler output, adding latency
  bit_sync2 #(.W(1)) u_pre_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .d     (pre_level),
    .q     (pre_level_s)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_level_d_r <= 1'b0;
    end else begin
      pre_level_d_r <= pre_level_s;
    end
  end

  wire sync_edge = (pre_level_s != pre_level_d_r) && !sleep_mode;
  wire inc_ext   = bypass ? pre_pulse : sync_edge;
  wire inc       = run && (ext ? inc_ext : pre_pulse);

  // ****************************************************
  // count, trigger and overflow
  // ****************************************************
  // asynchronous counting does not honour the trigger clear
  wire trig_clr = ccu_trigger && (ccu_mode_field == CCU_SPECIAL_TRIGGER)
                  && !bypass;
  wire wrap     = inc && (count_r == COUNT_MAX);

  always_comb begin
    count_nxt = count_r;
    if (wr_count) begin
      // write wins over trigger and increment
      if (wr_low) begin
        count_nxt[7:0] = req.pwdata[7:0];
      end else begin
        count_nxt[15:8] = req.pwdata[7:0];
      end
    end else if (trig_clr) begin
      count_nxt = 16'h0000;
    end else if (inc) begin
      count_nxt = count_r + 16'h0001;
    end
  end

  // no reset: the count survives every reset
  always_ff @(posedge ref_clk) begin
    count_r <= count_nxt;
  end

  // hardware set wins over a software clear in the same cycle
  always_comb begin
    flag_nxt = flag_r;
    if (wr_flag) begin
      flag_nxt = req.pwdata[OVF_BIT];
    end
    if (wrap && !wr_count && !trig_clr) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= FLAG_RESET;
      ien_r  <= IEN_RESET;
    end else if (other_reset) begin
      flag_r <= FLAG_RESET;
      ien_r  <= IEN_RESET;
    end else begin
      flag_r <= flag_nxt;
      if (wr_ien) begin
        ien_r <= req.pwdata[OVF_BIT];
      end
    end
  end

  // ****************************************************
  // outputs to the rest of the chip
  // ****************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_irq   <= 1'b0;
      timebase_valid <= 1'b0;
    end else begin
      overflow_irq   <= flag_r && ien_r;
      timebase_valid <= !bypass;
    end
  end

  assign count_value = count_r;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_WRAP_TO_ZERO: assert property (
    wrap && !wr_count && !trig_clr |=> count_r == 16'h0000)
    else $error("count did not wrap to zero");

  AST_WRAP_SETS_FLAG: assert property (
    wrap && !wr_count && !trig_clr && !other_reset |=> flag_r)
    else $error("wrap did not set overflow flag");

  AST_IRQ_FOLLOWS: assert property (
    flag_r && ien_r |=> overflow_irq)
    else $error("enabled flag did not raise interrupt");

  AST_HALT_HOLDS: assert property (
    !run && !wr_count && !trig_clr |=> $stable(count_r))
    else $error("halted counter changed");

  AST_OSC_PINS_INPUT: assert property (
    osc_en && $stable(osc_en) |=> portc_pin_oe == 2'b00
      && portc_read == 2'b00)
    else $error("oscillator pins not forced to input");

  AST_TRIGGER_CLEARS: assert property (
    trig_clr && !wr_count |=> count_r == 16'h0000)
    else $error("special event trigger did not clear count");

  AST_TRIGGER_NO_FLAG: assert property (
    trig_clr && !flag_r && !wr_flag |=> !flag_r)
    else $error("trigger clear set overflow flag");

  AST_WRITE_BEATS_TRIGGER: assert property (
    wr_low && trig_clr |=> count_r[7:0] == $past(req.pwdata[7:0]))
    else $error("trigger overrode count write");

  AST_ASYNC_NO_TIMEBASE: assert property (
    bypass ##1 bypass |=> !timebase_valid)
    else $error("async counter offered as timebase");

  AST_INTERNAL_RATE: assert property (
    inc && !ext |-> pre_pulse)
    else $error("internal count took external path");

endmodule

// file: design/tmr_pkg.sv
package tmr_pkg;

  // ****************************************************
  // register map: printed offsets are indices, byte = 4x
  // ****************************************************
  localparam int          ADDR_W     = 12;
  localparam logic [7:0]  FLAG_IDX   = 8'h0c;
  localparam logic [7:0]  LOW_IDX    = 8'h0e;
  localparam logic [7:0]  HIGH_IDX   = 8'h0f;
  localparam logic [7:0]  CTRL_IDX   = 8'h10;
  localparam logic [7:0]  IEN_IDX    = 8'h8c;
  localparam logic [11:0] FLAG_ADDR  = {2'b00, FLAG_IDX, 2'b00};
  localparam logic [11:0] LOW_ADDR   = {2'b00, LOW_IDX, 2'b00};
  localparam logic [11:0] HIGH_ADDR  = {2'b00, HIGH_IDX, 2'b00};
  localparam logic [11:0] CTRL_ADDR  = {2'b00, CTRL_IDX, 2'b00};
  localparam logic [11:0] IEN_ADDR   = {2'b00, IEN_IDX, 2'b00};

  // ****************************************************
  // field layout and reset values
  // ****************************************************
  localparam int          OVF_BIT    = 0;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [7:0]  CTRL_MASK  = 8'h3f;
  localparam logic        FLAG_RESET = 1'b0;
  localparam logic        IEN_RESET  = 1'b0;
  localparam logic [15:0] COUNT_MAX  = 16'hffff;
  localparam logic [3:0]  CCU_SPECIAL_TRIGGER = 4'hb;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_HZ        = 100_000_000;
  localparam int FOSC_DIVISOR  = 4;
  localparam int INSTR_HZ      = CLK_HZ / FOSC_DIVISOR;
  localparam int INSTR_CYCLES  = CLK_HZ / INSTR_HZ;

  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] input_divide_select;
    logic       crystal_osc_enable;
    logic       sync_bypass;
    logic       source_select;
    logic       run_bit;
  } counter_control_t;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [31:0]       pwdata;
  } apb_req_t;

endpackage

// file: sim/count_source.sv
`timescale 1ns/10ps
module count_source (
  input  wire logic       ref_clk,
  input  wire logic       req,
  input  wire logic [7:0] n_edges,
  input  wire logic       use_xtal,
  input  wire logic [3:0] half,
  output logic            ext_pin,
  output logic            xtal_pin,
  output logic            busy
);
  initial begin
    ext_pin = 1'b0;
    xtal_pin = 1'b0;
    busy = 1'b0;
  end

  // ****************************************************
  // burst of rising edges on the chosen pin
  // ****************************************************
  // both pins stand low between bursts, as a stopped source does
  always begin
    do @(posedge ref_clk); while (req !== 1'b1);
    busy <= 1'b1;
    repeat (n_edges) begin
      repeat ((half < 2) ? 2 : half) @(posedge ref_clk);
      {xtal_pin, ext_pin} <= use_xtal ? 2'b10 : 2'b01;
      repeat ((half < 2) ? 2 : half) @(posedge ref_clk);
      {xtal_pin, ext_pin} <= 2'b00;
    end
    busy <= 1'b0;
  end
endmodule

// file: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import tmr_pkg::*;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        other_reset = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_count_pin;
  logic        crystal_in_pin;
  logic [1:0]  portc_direction = 2'b00;
  logic [1:0]  portc_pin_in = 2'b11;
  logic [1:0]  portc_pin_oe;
  logic [1:0]  portc_read;
  logic        sleep_mode = 1'b0;
  logic        ccu_trigger = 1'b0;
  logic [3:0]  ccu_mode_field = 4'hb;
  logic [15:0] count_value;
  logic        timebase_valid;
  logic        overflow_irq;
  logic        src_req = 1'b0;
  logic [7:0]  src_n = 8'h00;
  logic        src_xtal = 1'b0;
  logic [3:0]  src_half = 4'h3;
  logic        src_busy;
  logic        trig_wr = 1'b0;
  logic [31:0] rd;
  logic        err;
  int          error_cnt = 0;
  int          n_checks = 0;

  always #5 ref_clk = ~ref_clk;

  sixteen_bit_timer_counter i_dut (
    .ref_clk, .resetn, .other_reset, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .ext_count_pin, .crystal_in_pin,
    .portc_direction, .portc_pin_in, .portc_pin_oe, .portc_read,
    .sleep_mode, .ccu_trigger, .ccu_mode_field, .count_value,
    .timebase_valid, .overflow_irq
  );

  count_source i_src (
    .ref_clk, .req(src_req), .n_edges(src_n), .use_xtal(src_xtal),
    .half(src_half), .ext_pin(ext_count_pin), .xtal_pin(crystal_in_pin),
    .busy(src_busy)
  );

  // ****************************************************
  // shared tasks
  // ****************************************************
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // the trigger, when asked for, is sampled at the commit edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    ccu_trigger <= trig_wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    ccu_trigger <= 1'b0;
    if (n >= 50) error_cnt++;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rdchk(string what, logic [11:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, err);
    check(what, rd, exp);
  endtask

  task automatic setcnt(input logic [15:0] v, input logic [7:0] c);
    wr(CTRL_ADDR, 32'h00);
    wr(LOW_ADDR, {24'h0, v[7:0]});
    wr(HIGH_ADDR, {24'h0, v[15:8]});
    wr(CTRL_ADDR, {24'h0, c});
  endtask

  task automatic trig();
    @(posedge ref_clk);
    ccu_trigger <= 1'b1;
    @(posedge ref_clk);
    ccu_trigger <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  // extra wait after the burst covers the synchroniser lag
  task automatic pulses(logic [7:0] n, logic x, logic [3:0] h);
    int k;
    k = 0;
    src_n <= n;
    src_xtal <= x;
    src_half <= h;
    src_req <= 1'b1;
    @(posedge ref_clk);
    src_req <= 1'b0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (src_busy === 1'b1 && k < 2000);
    if (k >= 2000) error_cnt++;
    repeat (16) @(posedge ref_clk);
  endtask

  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic s_regs();
    rdchk("ctrl reset", CTRL_ADDR, 32'h00);
    check("timebase sync", {31'h0, timebase_valid}, 32'h1);
    wr(CTRL_ADDR, 32'hff);
    rdchk("ctrl bits", CTRL_ADDR, 32'h3f);
    wr(CTRL_ADDR, 32'h00);
    apb(1'b0, 12'h100, 32'h0, rd, err);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
  endtask

  task automatic s_timer();
    int exp;
    logic [15:0] v;
    for (int d = 0; d < 4; d++) begin
      setcnt(16'h0000, {2'b00, 2'(d), 1'b0, 1'(d), 2'b01});
      repeat (400) @(posedge ref_clk);
      wr(CTRL_ADDR, 32'h00);
      @(posedge ref_clk);
      v = count_value;
      exp = 100 >> d;
      check("tick rate", {31'h0, (v >= exp - 2 && v <= exp + 2)},
            1);
      repeat (20) @(posedge ref_clk);
      check("halted", count_value, v);
    end
  endtask

  task automatic s_wrap();
    int n;
    n = 0;
    setcnt(16'hfffd, 8'h00);
    wr(FLAG_ADDR, 32'h0);
    wr(IEN_ADDR, 32'h1);
    wr(CTRL_ADDR, 32'h01);
    while (count_value !== 16'h0000 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    check("wrap", count_value, 32'h0);
    repeat (3) @(posedge ref_clk);
    check("irq", {31'h0, overflow_irq}, 32'h1);
    wr(CTRL_ADDR, 32'h00);
    rdchk("flag", FLAG_ADDR, 32'h1);
    wr(IEN_ADDR, 32'h0);
    repeat (3) @(posedge ref_clk);
    check("irq masked", {31'h0, overflow_irq}, 32'h0);
    wr(FLAG_ADDR, 32'h0);
  endtask

  // clearing from ffff looks like a wrap, so a wrongly set flag shows
  task automatic s_trig();
    setcnt(16'hffff, 8'h00);
    trig();
    check("trig clear", count_value, 32'h0);
    rdchk("trig flag", FLAG_ADDR, 32'h0);
    setcnt(16'h1234, 8'h00);
    trig_wr = 1'b1;
    wr(LOW_ADDR, 32'h56);
    trig_wr = 1'b0;
    @(posedge ref_clk);
    check("write wins", count_value, 32'h1256);
    ccu_mode_field <= 4'ha;
    trig();
    check("other mode", count_value, 32'h1256);
    ccu_mode_field <= 4'hb;
    wr(CTRL_ADDR, 32'h07);
    trig();
    check("async trig", count_value, 32'h1256);
    check("timebase async", {31'h0, timebase_valid}, 32'h0);
  endtask

  task automatic s_ext();
    setcnt(16'h0000, 8'h03);
    repeat (4) @(posedge ref_clk);
    check("oe", portc_pin_oe, 32'h3);
    check("port read", portc_read, 32'h3);
    pulses(8'd5, 1'b0, 4'h3);
    check("ext pin", count_value, 32'h5);
    wr(CTRL_ADDR, 32'h0b);
    repeat (20) @(posedge ref_clk);
    check("oe forced", portc_pin_oe, 32'h0);
    check("read zero", portc_read, 32'h0);
    pulses(8'd3, 1'b1, 4'h6);
    check("xtal pin", count_value, 32'h8);
    sleep_mode <= 1'b1;
    pulses(8'd4, 1'b1, 4'h3);
    check("sleep sync", count_value, 32'h8);
    wr(CTRL_ADDR, 32'h0f);
    pulses(8'd4, 1'b1, 4'h2);
    check("sleep async", count_value, 32'hc);
    rdchk("high byte", HIGH_ADDR, 32'h00);
    rdchk("low byte", LOW_ADDR, 32'h0c);
    rdchk("high again", HIGH_ADDR, 32'h00);
    sleep_mode <= 1'b0;
    setcnt(16'h0000, 8'h33);
    // five plus five would reach eight if the write left the partial count
    pulses(8'd5, 1'b0, 4'h3);
    wr(LOW_ADDR, 32'h0);
    pulses(8'd5, 1'b0, 4'h3);
    check("part cleared", count_value, 32'h0);
    pulses(8'd11, 1'b0, 4'h3);
    check("div eight", count_value, 32'h2);
  endtask

  task automatic s_reset();
    setcnt(16'h5a5a, 8'h30);
    wr(IEN_ADDR, 32'h1);
    @(posedge ref_clk);
    other_reset <= 1'b1;
    @(posedge ref_clk);
    other_reset <= 1'b0;
    rdchk("ctrl kept", CTRL_ADDR, 32'h30);
    rdchk("ien cleared", IEN_ADDR, 32'h0);
    resetn <= 1'b0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check("count kept", count_value, 32'h5a5a);
    rdchk("ctrl por", CTRL_ADDR, 32'h00);
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    s_regs();
    s_timer();
    s_wrap();
    s_trig();
    s_ext();
    s_reset();
    conclude();
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    conclude();
  end
endmodule
